// ==== hw/vdnfc_pkg.sv ====
package vdnfc_pkg;

  localparam int DATA_W          = 16;
  localparam int STAMP_W         = 32;
  localparam int LATENCY_EXTRA   = 17;
  localparam int LINE_FLUSH_CYC  = 20;
  localparam int LINE_PIXELS_DEF = 1920;
  localparam int FRAME_LINES_DEF = 1080;
  localparam int DEPTH_DEF       = 4096;
  localparam logic RESET_READY   = 1'b0;
  localparam logic [2:0] RESET_VALID = 3'h0;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              sof;
    logic              eol;
  } vdnfc_beat_t;

  typedef struct packed {
    vdnfc_beat_t        beat;
    logic [DATA_W-1:0]  prev;
    logic [STAMP_W-1:0] stamp;
  } vdnfc_entry_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_LFLUSH = 2'b01,
    ST_FFLUSH = 2'b10
  } vdnfc_state_t;

endpackage

// ==== hw/vdnfc_flow_ctrl.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Output no sooner than line plus 17
// - One pixel in, one out, per cycle
// - Output stops once buffer drains without input
// - Input stops once buffer full under back-pressure
// - End of line: 20 cycles, readies low
// - End of frame: flush one line time
// - Reset asserted; block resets at once, no clock edge needed
// - Clock enable low freezes everything
module vdnfc_flow_ctrl
  import vdnfc_pkg::*;
#(
  parameter int LINE_PIXELS = LINE_PIXELS_DEF,
  parameter int FRAME_LINES = FRAME_LINES_DEF,
  parameter int DEPTH       = DEPTH_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire vdnfc_beat_t currBeat,
  input  wire logic        currValid,
  output logic             currReady,
  input  wire vdnfc_beat_t prevBeat,
  input  wire logic        prevValid,
  output logic             prevReady,
  output vdnfc_beat_t      outBeat,
  output logic             outValid,
  input  wire logic        outReady,
  output vdnfc_beat_t      memBeat,
  output logic             memValid,
  input  wire logic        memReady,
  output vdnfc_beat_t      motionBeat,
  output logic             motionValid,
  input  wire logic        motionReady
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam int FL_W  = $clog2(LINE_PIXELS + LINE_FLUSH_CYC + 1);
  localparam int LN_W  = $clog2(FRAME_LINES + 1);
  localparam logic [STAMP_W-1:0] LAT =
    STAMP_W'(LINE_PIXELS + LATENCY_EXTRA);
  localparam logic [FL_W-1:0] LFLUSH_LOAD = FL_W'(LINE_FLUSH_CYC - 1);
  localparam logic [FL_W-1:0] FFLUSH_LOAD = FL_W'(LINE_PIXELS - 1);
  localparam logic [LN_W-1:0] LAST_LINE   = LN_W'(FRAME_LINES - 1);
  localparam logic [CNT_W-1:0] FULL_CNT   = CNT_W'(DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // State

  vdnfc_entry_t        store [DEPTH];
  logic [PTR_W-1:0]    wrPtr_q, rdPtr_q;
  logic [CNT_W-1:0]    count_q, count_d;
  logic [STAMP_W-1:0]  now_q;
  vdnfc_state_t        state_q, state_d;
  logic [FL_W-1:0]     flushCnt_q, flushCnt_d;
  logic [LN_W-1:0]     lineCnt_q, lineCnt_d;
  logic                inReady_q, inReady_d;
  logic [2:0]          vld_q, vld_d;
  vdnfc_beat_t         outBeat_q, motionBeat_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire                accept   = clkEn & inReady_q & currValid
                                 & prevValid;
  wire                eolSeen  = accept & currBeat.eol;
  wire                lastLine = (lineCnt_q == LAST_LINE);
  wire vdnfc_entry_t  head     = store[rdPtr_q];
  wire [STAMP_W-1:0]  age      = now_q - head.stamp;
  wire                ripe     = (count_q != '0) & (age >= LAT);
  wire [2:0]          rdyVec   = {motionReady, memReady, outReady};
  wire [2:0]          vldLeft  = vld_q & ~rdyVec;
  // Three consumers share one beat; the next waits for the slowest
  wire                pop      = clkEn & ripe & (vldLeft == 3'h0);
  wire vdnfc_entry_t  newEntry = '{beat: currBeat, prev: prevBeat.data,
                                   stamp: now_q};

  assign count_d = count_q + CNT_W'(accept) - CNT_W'(pop);
  // Registered ready, so judged on next count count_d; stops at full
  assign inReady_d = (state_d == ST_RUN) & (count_d < FULL_CNT);
  assign vld_d = pop ? 3'h7 : (clkEn ? vldLeft : vld_q);

  always_comb begin
    state_d    = state_q;
    flushCnt_d = flushCnt_q;
    lineCnt_d  = lineCnt_q;
    if (accept && currBeat.sof) begin
      lineCnt_d = currBeat.eol ? LN_W'(1) : '0;
    end
    case (state_q)
      ST_RUN: begin
        if (eolSeen && lastLine && !currBeat.sof) begin
          state_d    = ST_FFLUSH;
          flushCnt_d = FFLUSH_LOAD;
          lineCnt_d  = '0;
        end else if (eolSeen) begin
          state_d    = ST_LFLUSH;
          flushCnt_d = LFLUSH_LOAD;
          if (!currBeat.sof) begin
            lineCnt_d = lineCnt_q + LN_W'(1);
          end
        end
      end
      ST_LFLUSH, ST_FFLUSH: begin
        if (clkEn) begin
          if (flushCnt_q == '0) begin
            state_d = ST_RUN;
          end else begin
            flushCnt_d = flushCnt_q - FL_W'(1);
          end
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset forces readies low and drops all output valids
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inReady_q  <= RESET_READY;
      vld_q      <= RESET_VALID;
      state_q    <= ST_RUN;
      count_q    <= '0;
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      now_q      <= '0;
      flushCnt_q <= '0;
      lineCnt_q  <= '0;
    end else begin
      inReady_q  <= inReady_d;
      vld_q      <= vld_d;
      state_q    <= state_d;
      count_q    <= count_d;
      wrPtr_q    <= wrPtr_q + PTR_W'(accept);
      rdPtr_q    <= rdPtr_q + PTR_W'(pop);
      now_q      <= now_q + STAMP_W'(clkEn);
      flushCnt_q <= flushCnt_d;
      lineCnt_q  <= lineCnt_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outBeat_q    <= '0;
      motionBeat_q <= '0;
    end else if (pop) begin
      outBeat_q    <= head.beat;
      motionBeat_q <= '{data: head.prev, sof: head.beat.sof,
                        eol: head.beat.eol};
    end
  end

  // Line store has no reset; only written slots are ever read
  always_ff @(posedge core_clk) begin
    if (accept) begin
      store[wrPtr_q] <= newEntry;
    end
  end

  assign currReady   = inReady_q;
  assign prevReady   = inReady_q;
  assign outBeat     = outBeat_q;
  assign memBeat     = outBeat_q;
  assign motionBeat  = motionBeat_q;
  assign outValid    = vld_q[0];
  assign memValid    = vld_q[1];
  assign motionValid = vld_q[2];

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_LATENCY: assert property (
    pop |-> (now_q - head.stamp) >= LAT)
    else $error("pixel released before line latency");

  AST_FULL_RATE: assert property (
    (currReady && currValid && prevValid && clkEn) |=>
      (count_q == $past(count_q) + CNT_W'(1) - CNT_W'($past(pop))))
    else $error("offered pixel pair not consumed");

  AST_DRAIN: assert property (
    (count_q == '0 && vldLeft == 3'h0 && clkEn) |=> (vld_q == 3'h0))
    else $error("output valid without buffered data");

  AST_FULL_STOP: assert property (
    (count_q == FULL_CNT) |-> !currReady && !prevReady)
    else $error("ready shown while buffer full");

  AST_LINE_FLUSH: assert property (
    (eolSeen && !lastLine) |=> (!currReady && !prevReady)[*8] ##1
      (state_q == ST_LFLUSH))
    else $error("line flush too short");

  AST_FLUSH_END: assert property (
    (state_q == ST_LFLUSH && clkEn && flushCnt_q == '0
      && count_d < FULL_CNT) |=> (state_q == ST_RUN) && currReady)
    else $error("line flush did not end on count");

  AST_FRAME_FLUSH: assert property (
    (eolSeen && lastLine && !currBeat.sof) |=>
      (state_q == ST_FFLUSH) && (flushCnt_q == FFLUSH_LOAD)
      && !currReady)
    else $error("frame flush not entered");

  AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> !currReady && (vld_q == 3'h0))
    else $error("outputs active after reset");

  AST_FREEZE: assert property (
    !clkEn |=> $stable(count_q) && $stable(vld_q) && $stable(state_q))
    else $error("state moved while enable low");

  // A lone valid on either side must leave the buffer untouched
  AST_LOCKSTEP: assert property (
    (clkEn && (currValid != prevValid)) |=>
      (count_q == $past(count_q) - CNT_W'($past(pop))))
    else $error("lone valid taken into buffer");

  COV_STREAM: cover property (accept ##1 accept ##1 accept);
  COV_LFLUSH: cover property (state_q == ST_LFLUSH ##1 state_q == ST_RUN);
  COV_FFLUSH: cover property (state_q == ST_FFLUSH);
  COV_STALL:  cover property (vld_q != 3'h0 && vldLeft != 3'h0 && clkEn);

endmodule // vdnfc_flow_ctrl

// ==== bench/vdnfc_sink.sv ====
`timescale 1ns/100ps
// Downstream consumer; stall models a slow reader
module vdnfc_sink (
  input  wire logic core_clk,
  input  wire logic stall,
  output logic      ready
);
  // Moves off the sampling edge to avoid races
  always @(negedge core_clk) begin
    ready <= !stall;
  end
endmodule // vdnfc_sink

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import vdnfc_pkg::*;
  localparam int LP = 8;
  localparam int DP = 32;
  logic        core_clk, sys_rst, clkEn, stall;
  logic        currValid, prevValid, currReady, prevReady;
  logic        outValid, memValid, motionValid;
  vdnfc_beat_t currBeat, prevBeat, outBeat, memBeat, motionBeat;
  wire logic [2:0] rdy;
  int          err_count = 0, n_compared = 0, cyc = 0;
  vdnfc_beat_t inQ[$];
  int          inT[$];
  vdnfc_flow_ctrl #(.LINE_PIXELS(LP), .FRAME_LINES(3), .DEPTH(DP))
    vdnfc_flow_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .currBeat(currBeat), .currValid(currValid),
    .currReady(currReady), .prevBeat(prevBeat), .prevValid(prevValid),
    .prevReady(prevReady), .outBeat(outBeat), .outValid(outValid),
    .outReady(rdy[2]), .memBeat(memBeat), .memValid(memValid),
    .memReady(rdy[1]), .motionBeat(motionBeat),
    .motionValid(motionValid), .motionReady(rdy[0]));
  vdnfc_sink vdnfc_sink_i[2:0] (.core_clk(core_clk), .stall(stall),
    .ready(rdy));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Scoreboard: pairs in order, prev pixel carried on motion
  always @(posedge core_clk) begin
    if (!sys_rst && clkEn) begin
      cyc++;
      if (currValid && prevValid && currReady === 1'b1) begin
        inQ.push_back(currBeat);
        inT.push_back(cyc);
      end
      if (outValid === 1'b1 && rdy[2]) begin
        check(outBeat, inQ[0]);
        check(motionBeat, {~inQ[0].data, inQ[0].sof, inQ[0].eol});
        check(cyc - inT[0] >= LP + LATENCY_EXTRA, 1);
        check({memBeat, memValid, motionValid}, {inQ[0], 2'b11});
        inQ.pop_front();
        inT.pop_front();
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic push(input logic [15:0] d, input logic s, input logic e);
    int k;
    currBeat = '{d, s, e};
    prevBeat = '{~d, 1'b0, 1'b0};
    currValid = 1'b1;
    prevValid = 1'b1;
    for (k = 0; currReady !== 1'b1; k++) begin
      if (k > 300) begin
        err_count++;
        tally_and_finish();
      end
      @(negedge core_clk);
    end
    @(negedge core_clk);
  endtask
  task automatic line(input int base, input logic s, input int gap);
    int n;
    for (n = 0; n < LP; n++) push(16'(base + n), s && n == 0, n == LP - 1);
    currValid = 1'b0;
    prevValid = 1'b0;
    for (n = 0; currReady === 1'b0 && n < 2000; n++) @(negedge core_clk);
    check(n, gap);
  endtask
  // A lone valid must not be taken; a leak shows as a stray pixel
  task automatic frame;
    currValid = 1'b1;
    repeat (6) @(negedge core_clk);
    currValid = 1'b0;
    prevValid = 1'b1;
    repeat (6) @(negedge core_clk);
    line(16'h0010, 1'b1, LINE_FLUSH_CYC);
    line(16'h0020, 1'b0, LINE_FLUSH_CYC);
    line(16'h0030, 1'b0, LP);
    repeat (60) @(negedge core_clk);
    check(inQ.size(), 0);
    check(outValid, 1'b0);
  endtask
  // Stalled consumers fill the buffer, then a frozen enable holds all
  task automatic fill;
    int t;
    t = 0;
    stall = 1'b1;
    currValid = 1'b1;
    prevValid = 1'b1;
    repeat (80) begin
      currBeat = '{16'(16'h0100 + t), t == 0, 1'b0};
      prevBeat = '{~16'(16'h0100 + t), 1'b0, 1'b0};
      if (currReady === 1'b1) t++;
      @(negedge core_clk);
    end
    check(t >= DP && t <= DP + 2, 1);
    stall = 1'b0;
    clkEn = 1'b0;
    repeat (6) @(negedge core_clk);
    check({outValid, currReady}, 2'b10);
    clkEn = 1'b1;
    currValid = 1'b0;
    prevValid = 1'b0;
    repeat (200) @(negedge core_clk);
    check(inQ.size(), 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    stall = 1'b0;
    currValid = 1'b0;
    prevValid = 1'b0;
    currBeat = '0;
    prevBeat = '0;
    repeat (32) @(negedge core_clk);
    check({currReady, prevReady, outValid}, 3'h0);
    sys_rst = 1'b0;
    @(negedge core_clk);
    frame();
    fill();
    tally_and_finish();
  end
endmodule // tb_top
